// ==== core/fdp_pkg.sv ====
// Shared constants and carriers for the floppy drive control port
package fdp_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CLK_NS = 25;
  // Spin-up waits
  localparam int unsigned SPIN_SHORT_NS = 40;
  localparam int unsigned SPIN_LONG_MS = 1000;
  localparam int unsigned SPIN_SHORT_CYC = (SPIN_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SPIN_LONG_CYC = SPIN_LONG_MS * (CLK_HZ / 1000);
  // Idle motor shut-off
  localparam int unsigned IDLE_OFF_MS = 3000;
  localparam int unsigned IDLE_OFF_CYC = IDLE_OFF_MS * (CLK_HZ / 1000);
  // Restore floor on step period
  localparam int unsigned RESTORE_MIN_MS = 8;
  localparam int unsigned RESTORE_MIN_CYC = RESTORE_MIN_MS * (CLK_HZ / 1000);
  // Step pulse width and one step-rate unit
  localparam int unsigned STEP_PULSE_NS = 1000;
  localparam int unsigned STEP_PULSE_CYC = STEP_PULSE_NS / CLK_NS;
  localparam int unsigned RATE_UNIT_US = 500;
  localparam int unsigned RATE_UNIT_CYC = RATE_UNIT_US * (CLK_HZ / 1000000);
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_WIDTH = 8;
  localparam logic [3:0] RATE_RESET = 4'h0;

  typedef enum logic {
    FDP_DIR_IN,
    FDP_DIR_OUT
  } fdp_dir_e;

  // Seek request from the command sequencer
  typedef struct packed {
    logic [7:0] steps;
    logic outward;
    logic restore;
    logic explicitRate;
    logic [3:0] rate;
  } fdp_seek_s;
endpackage

// ==== core/fdp_fifo.sv ====
// Write-data FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module fdp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic doWr;
  logic doRd;

  assign inReady = (count != AW'(0) + (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  assign outData = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWr) begin
        wrPtr <= wrPtr + AW'(1);
      end
      if (doRd) begin
        rdPtr <= rdPtr + AW'(1);
      end
      if (doWr && !doRd) begin
        count <= count + (AW+1)'(1);
      end else if (doRd && !doWr) begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule // fdp_fifo
`default_nettype wire

// ==== core/fdp_control_port.sv ====
// Floppy drive control port: select, motor, stepping and write path
// How it works
// [R1] Drive pulses rotation_marker once per revolution, marking track start.
// [R2] One-hot unit_select_lines address exactly one of four drives.
// [R3] Spin-up wait before read/write: 40 ns if jumper 0, else one second. Here only writes wait on driveReady; readBit is not held off.
// [R4] Motor switches off after about three seconds with no access.
// [R5] Drives load heads whenever spindle power is on.
// [R6] head_direction high steps outward, low steps inward.
// [R7] One step pulse per cylinder travelled, direction from head_direction.
// [R8] Step interval from internal rate, or from explicit command rate.
// [R9] Restore never steps faster than one pulse per 8 ms.
// [R10] Write data only passes while write_gate is asserted.
// [R11] Drive raises outer_cylinder_flag on the outermost cylinder.
// [R12] outer_cylinder_flag is sampled before every step pulse.
// [R13] No write while media_locked_flag is active.
// [R14] Drive delivers raw undecoded clock-and-data read stream.
// [R15] head_side_choice selects the disk surface.
// [R16] Every access restarts the motor idle timer.
`timescale 1ns/10ps
`default_nettype none
module fdp_control_port
  import fdp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // Sequencer side
  input wire logic [1:0] driveNum,
  input wire logic sideSel,
  input wire logic motorReq,
  input wire logic spin_up_delay_select,
  input wire logic [3:0] internalRate,
  input wire logic seekStart,
  input wire fdp_seek_s seekCmd,
  output logic seekBusy,
  output logic seekDone,
  output logic atOuter,
  output logic driveReady,
  input wire logic writeReq,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [FIFO_WIDTH-1:0] wrData,
  output logic writeRefused,
  output logic readBit,
  output logic indexSeen,
  // Drive side
  input wire logic rotation_marker,
  input wire logic outer_cylinder_flag,
  input wire logic media_locked_flag,
  input wire logic raw_read_stream,
  output logic [3:0] unit_select_lines,
  output logic spindle_power_on,
  output logic head_direction,
  output logic stepPulse,
  output logic disk_write_bits,
  output logic write_gate,
  output logic head_side_choice
);
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_PULSE, ST_WAIT} fdp_step_e;

  function automatic logic [3:0] decode_unit(input logic [1:0] n);
    decode_unit = 4'h1 << n;
  endfunction
  function automatic logic [31:0] rate_cycles(input logic [3:0] r);
    rate_cycles = (32'(r) + 32'h1) * RATE_UNIT_CYC;
  endfunction

  fdp_step_e state;
  logic [31:0] idleCnt;
  logic [31:0] spinCnt;
  logic [31:0] gapCnt;
  logic [31:0] gapLen;
  logic [7:0] stepsLeft;
  logic isRestore;
  logic access;
  logic writing;
  logic fifoValid;
  logic [FIFO_WIDTH-1:0] fifoData;
  logic [2:0] bitIdx;
  logic [FIFO_WIDTH-1:0] shiftReg;
  logic markPrev;
  logic shiftOn;

  assign access = seekStart || writeReq || (motorReq && !spindle_power_on);

  // -----------------------------------------------------------------
  // Drive select and side
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unit_select_lines <= 4'h0;
      head_side_choice <= 1'b0;
    end else begin
      unit_select_lines <= decode_unit(driveNum); // R2
      head_side_choice <= sideSel; // R15
    end
  end

  // -----------------------------------------------------------------
  // Motor and idle timer; heads load with the motor on the drive side
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spindle_power_on <= 1'b0;
      idleCnt <= '0;
    end else if (access && motorReq) begin
      spindle_power_on <= 1'b1; // R5
      idleCnt <= '0; // R16
    end else if (spindle_power_on) begin
      if (seekBusy || writing) begin
        idleCnt <= '0; // R16
      end else if (idleCnt >= IDLE_OFF_CYC - 1) begin
        spindle_power_on <= 1'b0; // R4
        idleCnt <= '0;
      end else begin
        idleCnt <= idleCnt + 32'h1;
      end
    end
  end

  // Spin-up wait gates every write; readBit is not held off by it
  always_ff @(posedge clk) begin
    if (sys_rst || !spindle_power_on) begin
      spinCnt <= '0;
      driveReady <= 1'b0;
    end else if (!driveReady) begin
      if (spinCnt >= (spin_up_delay_select ? SPIN_LONG_CYC : SPIN_SHORT_CYC) - 1) begin
        driveReady <= 1'b1; // R3
      end
      spinCnt <= spinCnt + 32'h1;
    end
  end

  // -----------------------------------------------------------------
  // Stepper
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      stepsLeft <= '0;
      isRestore <= 1'b0;
      head_direction <= 1'b0;
      gapLen <= '0;
      gapCnt <= '0;
      stepPulse <= 1'b0;
      seekDone <= 1'b0;
      atOuter <= 1'b0;
    end else begin
      seekDone <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (seekStart) begin
            // Restore always heads outward and runs until the outer flag
            isRestore <= seekCmd.restore;
            stepsLeft <= seekCmd.steps;
            head_direction <= seekCmd.restore | seekCmd.outward; // R6
            gapLen <= rate_cycles(seekCmd.explicitRate ? seekCmd.rate : internalRate); // R8
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          atOuter <= outer_cylinder_flag; // R12
          if (isRestore && gapLen < RESTORE_MIN_CYC) begin
            gapLen <= RESTORE_MIN_CYC; // R9
          end
          if ((isRestore && outer_cylinder_flag) || (!isRestore && stepsLeft == 8'h0)) begin
            seekDone <= 1'b1;
            state <= ST_IDLE;
          end else begin
            stepPulse <= 1'b1; // R7
            gapCnt <= '0;
            state <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          gapCnt <= gapCnt + 32'h1;
          if (gapCnt >= STEP_PULSE_CYC - 1) begin
            stepPulse <= 1'b0;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          gapCnt <= gapCnt + 32'h1;
          if (gapCnt >= gapLen - 1) begin
            if (!isRestore) begin
              stepsLeft <= stepsLeft - 8'h1; // R7
            end
            state <= ST_CHECK;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign seekBusy = (state != ST_IDLE);

  // -----------------------------------------------------------------
  // Write path
  // -----------------------------------------------------------------
  // Write is refused on a locked disk; data then stays queued.
  assign writeRefused = media_locked_flag; // R13

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      writing <= 1'b0;
    end else begin
      writing <= writeReq && driveReady && !media_locked_flag; // R13
    end
  end

  // A started byte is shifted out in full even when the queue runs dry behind it
  assign shiftOn = writing && !media_locked_flag && (fifoValid || bitIdx != 3'h7); // R13
  fdp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) wrFifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .inValid(wrValid),
    .inReady(wrReady),
    .inData(wrData),
    .outValid(fifoValid),
    .outReady(shiftOn && bitIdx == 3'h7),
    .outData(fifoData)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bitIdx <= 3'h7;
      shiftReg <= '0;
      write_gate <= 1'b0;
      disk_write_bits <= 1'b0;
    end else begin
      write_gate <= shiftOn;
      if (shiftOn) begin
        disk_write_bits <= (bitIdx == 3'h7) ? fifoData[7] : shiftReg[7]; // R10
        shiftReg <= (bitIdx == 3'h7) ? {fifoData[6:0], 1'b0} : {shiftReg[6:0], 1'b0};
        bitIdx <= bitIdx + 3'h1;
      end else begin
        disk_write_bits <= 1'b0; // R10
        bitIdx <= 3'h7;
      end
    end
  end

  // -----------------------------------------------------------------
  // Read stream and index
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readBit <= 1'b0;
      markPrev <= 1'b0;
      indexSeen <= 1'b0;
    end else begin
      readBit <= raw_read_stream;
      markPrev <= rotation_marker;
      indexSeen <= rotation_marker && !markPrev;
    end
  end

  property p_motor_wait;
    @(posedge clk) disable iff (sys_rst)
    $rose(spindle_power_on) && !spin_up_delay_select |-> !driveReady [*2]; // R3
  endproperty
  a_motor_wait: assert property (p_motor_wait) else $error("ready too early"); // R3
  property p_restore_dir;
    @(posedge clk) disable iff (sys_rst)
    stepPulse && isRestore |-> head_direction; // R6
  endproperty
  a_restore_dir: assert property (p_restore_dir) else $error("restore not outward"); // R6
  property p_gate_data;
    @(posedge clk) disable iff (sys_rst)
    disk_write_bits |-> write_gate; // R10
  endproperty
  a_gate_data: assert property (p_gate_data) else $error("data without gate"); // R10
  property p_locked;
    @(posedge clk) disable iff (sys_rst)
    media_locked_flag |=> !writing && !write_gate; // R13
  endproperty
  a_locked: assert property (p_locked) else $error("write while locked"); // R13
  property p_restore_floor;
    @(posedge clk) disable iff (sys_rst)
    state == ST_WAIT && isRestore |-> gapLen >= RESTORE_MIN_CYC; // R9
  endproperty
  a_restore_floor: assert property (p_restore_floor) else $error("restore too fast"); // R9
  property p_one_select;
    @(posedge clk) disable iff (sys_rst)
    $past(!sys_rst) |-> $onehot(unit_select_lines); // R2
  endproperty
  a_one_select: assert property (p_one_select) else $error("select not one-hot"); // R2
  property p_check_first;
    @(posedge clk) disable iff (sys_rst)
    $rose(stepPulse) |-> $past(state) == ST_CHECK; // R12
  endproperty
  a_check_first: assert property (p_check_first) else $error("step without check"); // R12
  property p_side;
    @(posedge clk) disable iff (sys_rst)
    ##1 head_side_choice == $past(sideSel); // R15
  endproperty
  a_side: assert property (p_side) else $error("side mismatch"); // R15
endmodule // fdp_control_port
`default_nettype wire

// ==== testbench/fdp_drive_model.sv ====
// Behavioural model of a single floppy drive; it ignores the unit select lines
`timescale 1ns/10ps
`default_nettype none
module fdp_drive_model #(
  parameter int START_CYL = 0,
  parameter int REV_CYC = 4000
) (
  input wire logic clk,
  input wire logic spindle_power_on,
  input wire logic head_direction,
  input wire logic stepPulse,
  input wire logic lockReq,
  output logic rotation_marker,
  output logic outer_cylinder_flag,
  output logic media_locked_flag,
  output logic raw_read_stream
);
  int cyl = START_CYL;
  int revCnt = 0;
  logic prevStep = 1'b0;
  logic headsLoaded;
  logic [7:0] lfsr = 8'h5a;
  // ----------------------------------------
  // Head position and rotation
  // ----------------------------------------
  always @(posedge clk) begin
    prevStep <= stepPulse;
    if (stepPulse && !prevStep) begin
      cyl <= head_direction ? ((cyl > 0) ? cyl - 1 : 0) : cyl + 1;
    end
    revCnt <= (revCnt == REV_CYC - 1) ? 0 : revCnt + 1;
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  end
  // Index marks only appear while the spindle is powered; revCnt runs regardless
  assign rotation_marker = spindle_power_on && (revCnt < 4);
  assign outer_cylinder_flag = (cyl == 0);
  assign media_locked_flag = lockReq;
  // LFSR advances every cycle, so the bit is pseudo-random but can repeat; silent with heads unloaded
  assign raw_read_stream = headsLoaded & lfsr[0];
  assign headsLoaded = spindle_power_on;
endmodule // fdp_drive_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the floppy drive control port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fdp_pkg::*;
  localparam int LIMIT = 99000;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] driveNum = 2'h0;
  logic sideSel = 1'b0;
  logic motorReq = 1'b0;
  logic seekStart = 1'b0;
  logic [3:0] internalRate = 4'hf;
  fdp_seek_s seekCmd = '0;
  logic writeReq = 1'b0;
  logic wrValid = 1'b0;
  logic lockReq = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic seekBusy, seekDone, atOuter, driveReady, wrReady, writeRefused, readBit, indexSeen;
  logic rotMark, outerFlag, lockFlag, rawRead, spindle, headDir, stepPulse, wrBit, wrGate, side;
  logic [3:0] units;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  int nSteps = 0;
  int lastRise = 0;
  int nIdx = 0;
  int nSeen = 0;
  logic expDir = 1'b0;
  logic prevStep = 1'b0;
  logic prevMark = 1'b0;
  logic live = 1'b0;
  logic spinSel = 1'b0;
  logic prevRaw = 1'b0;
  logic rawOk = 1'b0;
  logic [31:0] rng = 32'h1e;
  logic bits[$];
  logic [7:0] q[$];

  fdp_control_port fdp_control_port_inst (.clk(clk), .sys_rst(sys_rst), .driveNum(driveNum),
    .sideSel(sideSel), .motorReq(motorReq), .spin_up_delay_select(spinSel),
    .internalRate(internalRate), .seekStart(seekStart), .seekCmd(seekCmd), .seekBusy(seekBusy),
    .seekDone(seekDone), .atOuter(atOuter), .driveReady(driveReady), .writeReq(writeReq),
    .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .writeRefused(writeRefused),
    .readBit(readBit), .indexSeen(indexSeen), .rotation_marker(rotMark),
    .outer_cylinder_flag(outerFlag), .media_locked_flag(lockFlag), .raw_read_stream(rawRead),
    .unit_select_lines(units), .spindle_power_on(spindle), .head_direction(headDir),
    .stepPulse(stepPulse), .disk_write_bits(wrBit), .write_gate(wrGate),
    .head_side_choice(side));
  fdp_drive_model fdp_drive_model_inst (.clk(clk), .spindle_power_on(spindle),
    .head_direction(headDir), .stepPulse(stepPulse), .lockReq(lockReq),
    .rotation_marker(rotMark), .outer_cylinder_flag(outerFlag),
    .media_locked_flag(lockFlag), .raw_read_stream(rawRead));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic int stepGap(input int r);
    return (r + 1) * int'(RATE_UNIT_CYC);
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic seek(input logic [7:0] n, input logic out, input logic rest, input logic expl);
    // The rate source not chosen is set slowest, so picking the wrong one overruns the wait
    internalRate = expl ? 4'hf : 4'h0;
    seekCmd = '{steps: n, outward: out, restore: rest, explicitRate: expl,
      rate: expl ? 4'h0 : 4'hf};
    expDir = out;
    nSteps = 0;
    seekStart = 1'b1;
    @(negedge clk);
    seekStart = 1'b0;
    for (int t = 0; t < 45000 && seekDone !== 1'b1; t++) @(negedge clk);
    check("seekDone", 1, seekDone);
    check("step count", n, nSteps);
  endtask

  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      test_done();
    end
  end

  // ----------------------------------------
  // Wire monitor
  // ----------------------------------------
  always @(negedge clk) begin
    if (live && stepPulse === 1'b1 && prevStep !== 1'b1) begin
      nSteps++;
      check("head_direction", expDir, headDir);
      if (nSteps > 1) check("step gap", 1, (cycles - lastRise) >= stepGap(0));
      if (nSteps > 1) check("step gap max", 1, (cycles - lastRise) < stepGap(1));
      lastRise = cycles;
    end
    prevStep = stepPulse;
    if (live && wrGate === 1'b1) begin
      bits.push_back(wrBit);
      if (lockFlag === 1'b1) check("gate while locked", 0, 1);
    end else if (live && wrBit !== 1'b0) check("disk_write_bits idle", 0, wrBit);
    if (rotMark === 1'b1 && prevMark !== 1'b1) nIdx++;
    prevMark = rotMark;
    if (indexSeen === 1'b1) nSeen++;
    if (live && sys_rst === 1'b0 && rawOk) check("readBit", prevRaw, readBit);
    prevRaw = rawRead;
    rawOk = (sys_rst === 1'b0);
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    check("spindle in reset", 0, spindle);
    check("step in reset", 0, stepPulse);
    check("gate in reset", 0, wrGate);
    sys_rst = 1'b0;
    live = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rng = xorshift(rng);
      driveNum = i[1:0];
      sideSel = rng[2];
      repeat (3) @(negedge clk);
      check("unit_select_lines", 32'h1 << i[1:0], units);
      check("head_side_choice", rng[2], side);
    end
    motorReq = 1'b1;
    for (int t = 0; t < 10 && spindle !== 1'b1; t++) @(negedge clk);
    check("spindle_power_on", 1, spindle);
    check("ready at power on", 0, driveReady);
    repeat (SPIN_SHORT_CYC + 2) @(negedge clk);
    check("driveReady", 1, driveReady);
    // Heads start on the outer cylinder, so restore needs no step
    seek(8'h00, 1'b1, 1'b1, 1'b1);
    check("atOuter", 1, atOuter);
    seek(8'h02, 1'b0, 1'b0, 1'b1);
    check("atOuter off", 0, atOuter);
    seek(8'h01, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (wrReady !== 1'b1) break;
      rng = xorshift(rng);
      wrValid = 1'b1;
      wrData = rng[7:0];
      q.push_back(rng[7:0]);
    end
    wrValid = 1'b0;
    check("fifo fill", FIFO_DEPTH, q.size());
    lockReq = 1'b1;
    writeReq = 1'b1;
    repeat (20) @(negedge clk);
    check("writeRefused", 1, writeRefused);
    check("bits while locked", 0, bits.size());
    lockReq = 1'b0;
    for (int t = 0; t < 400 && bits.size() < 8 * q.size(); t++) @(negedge clk);
    repeat (4) @(negedge clk);
    writeReq = 1'b0;
    check("bit count", 8 * FIFO_DEPTH, bits.size());
    foreach (q[i]) begin
      for (int j = 0; j < 8; j++) begin
        if (bits.size() > 8 * i + j) check("disk_write_bits", q[i][7-j], bits[8*i+j]);
      end
    end
    check("fifo drained", 1, wrReady);
    // Restore from cylinder 1 is cut by a reset inside its first gap, which the floor makes long
    expDir = 1'b1;
    nSteps = 0;
    seekCmd = '{steps: 8'h00, outward: 1'b0, restore: 1'b1, explicitRate: 1'b1, rate: 4'h0};
    seekStart = 1'b1;
    @(negedge clk);
    seekStart = 1'b0;
    repeat (100) @(negedge clk);
    check("restore steps", 1, nSteps);
    check("restore busy", 1, seekBusy);
    sys_rst = 1'b1;
    spinSel = 1'b1;
    repeat (2) @(negedge clk);
    check("busy in reset", 0, seekBusy);
    check("spindle in second reset", 0, spindle);
    sys_rst = 1'b0;
    repeat (200) @(negedge clk);
    check("spindle after reset", 1, spindle);
    check("long spin-up", 0, driveReady);
    check("index pulses", 1, nSeen + 1 >= nIdx && nSeen <= nIdx + 1);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
